// [shared/bram_consts.vh]
// constants for the dual-port block memory
// assumes inclusion by bare name from the design file
`ifndef BRAM_CONSTS_VH
`define BRAM_CONSTS_VH

`define DATA_BITS      16384
`define EXTRA_BITS     2048
`define FULL_ADDR_BITS 14
`define EXTRA_GROUP    9

// output behaviour during a write
`define MODE_NEW       2'h0
`define MODE_OLD       2'h1
`define MODE_HOLD      2'h2

// inversion mask bit positions
`define INV_STROBE     0
`define INV_GATE       1
`define INV_CLOCK      2
`define INV_PRESET     3

`define OUT_RESET      1'h0
`define CLK_RESET      1'h0

`endif

// [rtl/dual_port_block_ram_ports.v]
// dual-port block memory with two independently shaped ports
// assumes port clocks and all port inputs are synchronous to core_clk_in
`timescale 1ns/1ps
`include "bram_consts.vh"

module dual_port_block_ram_ports #(
	parameter        WIDTH_A    = 9,
	parameter        WIDTH_B    = 9,
	parameter        DW_A       = (WIDTH_A >= `EXTRA_GROUP) ? WIDTH_A * 8 / 9 : WIDTH_A,
	parameter        DW_B       = (WIDTH_B >= `EXTRA_GROUP) ? WIDTH_B * 8 / 9 : WIDTH_B,
	parameter        PW_A       = (WIDTH_A >= `EXTRA_GROUP) ? WIDTH_A / 9 : 0,
	parameter        PW_B       = (WIDTH_B >= `EXTRA_GROUP) ? WIDTH_B / 9 : 0,
	// zero-extra ports still carry one unused pin
	parameter        PP_A       = (PW_A == 0) ? 1 : PW_A,
	parameter        PP_B       = (PW_B == 0) ? 1 : PW_B,
	parameter        AW_A       = (DW_A == 1) ? 14 : (DW_A == 2) ? 13 : (DW_A == 4) ? 12 :
	                              (DW_A == 8) ? 11 : (DW_A == 16) ? 10 : 9,
	parameter        AW_B       = (DW_B == 1) ? 14 : (DW_B == 2) ? 13 : (DW_B == 4) ? 12 :
	                              (DW_B == 8) ? 11 : (DW_B == 16) ? 10 : 9,
	parameter  [3:0] INV_A      = 4'h0,
	parameter  [3:0] INV_B      = 4'h0,
	parameter  [1:0] MODE_A     = `MODE_NEW,
	parameter  [1:0] MODE_B     = `MODE_NEW,
	parameter  [DW_A-1:0] PRESET_A   = {DW_A{1'b0}},
	parameter  [DW_B-1:0] PRESET_B   = {DW_B{1'b0}},
	parameter  [PP_A-1:0] PRESET_X_A = {PP_A{1'b0}},
	parameter  [PP_B-1:0] PRESET_X_B = {PP_B{1'b0}}
) (
	input  wire            core_clk_in,
	input  wire            rst_in,
	input  wire            ce_in,
	input  wire            port_a_clock_in,
	input  wire            port_a_gate_in,
	input  wire            port_a_write_strobe_in,
	input  wire            port_a_sync_output_preset_in,
	input  wire [AW_A-1:0] port_a_location_in,
	input  wire [DW_A-1:0] port_a_write_word_in,
	input  wire [PP_A-1:0] port_a_extra_in,
	output reg  [DW_A-1:0] port_a_read_word_out,
	output reg  [PP_A-1:0] port_a_extra_out,
	input  wire            port_b_clock_in,
	input  wire            port_b_gate_in,
	input  wire            port_b_write_strobe_in,
	input  wire            port_b_sync_output_preset_in,
	input  wire [AW_B-1:0] port_b_location_in,
	input  wire [DW_B-1:0] port_b_write_word_in,
	input  wire [PP_B-1:0] port_b_extra_in,
	output reg  [DW_B-1:0] port_b_read_word_out,
	output reg  [PP_B-1:0] port_b_extra_out
);

	// bit-granular storage gives natural bus matching between widths
	reg        data_mem [0:`DATA_BITS-1];
	reg        extra_mem [0:`EXTRA_BITS-1];
	reg        clk_a_q;
	reg        clk_b_q;
	integer    wd;
	integer    wx;
	integer    ra;
	integer    rb;
	integer    base_a;
	integer    base_b;
	integer    xbase_a;
	integer    xbase_b;

	// port clocks are sampled, so each level must last one core cycle
	wire clk_a_now  = port_a_clock_in ^ INV_A[`INV_CLOCK];
	wire clk_b_now  = port_b_clock_in ^ INV_B[`INV_CLOCK];
	wire edge_a     = clk_a_now & ~clk_a_q;
	wire edge_b     = clk_b_now & ~clk_b_q;
	wire gate_a     = port_a_gate_in ^ INV_A[`INV_GATE];
	wire gate_b     = port_b_gate_in ^ INV_B[`INV_GATE];
	wire strobe_a   = port_a_write_strobe_in ^ INV_A[`INV_STROBE];
	wire strobe_b   = port_b_write_strobe_in ^ INV_B[`INV_STROBE];
	wire preset_a   = port_a_sync_output_preset_in ^ INV_A[`INV_PRESET];
	wire preset_b   = port_b_sync_output_preset_in ^ INV_B[`INV_PRESET];
	wire act_a      = edge_a & gate_a;
	wire act_b      = edge_b & gate_b;
	wire wr_a       = act_a & strobe_a;
	wire wr_b       = act_b & strobe_b;

	always @*
	begin
		base_a  = port_a_location_in * DW_A;
		base_b  = port_b_location_in * DW_B;
		xbase_a = port_a_location_in * PP_A;
		xbase_b = port_b_location_in * PP_B;
	end

	// edge memory reset state is the idle level of the un-inverted clock
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			clk_a_q <= `CLK_RESET;
			clk_b_q <= `CLK_RESET;
		end
		else if (ce_in)
		begin
			clk_a_q <= clk_a_now;
			clk_b_q <= clk_b_now;
		end
	end

	// data storage: port b is applied last, so it wins a same-cycle collision
	always @(posedge core_clk_in)
	begin
		if (ce_in && !rst_in)
		begin
			for (wd = 0; wd < DW_A; wd = wd + 1)
				if (wr_a)
					data_mem[base_a + wd] <= port_a_write_word_in[wd];
			for (wd = 0; wd < DW_B; wd = wd + 1)
				if (wr_b)
					data_mem[base_b + wd] <= port_b_write_word_in[wd];
		end
	end

	// extra storage: plain bits, same collision order as the data bits
	always @(posedge core_clk_in)
	begin
		if (ce_in && !rst_in)
		begin
			for (wx = 0; wx < PW_A; wx = wx + 1)
				if (wr_a)
					extra_mem[xbase_a + wx] <= port_a_extra_in[wx];
			for (wx = 0; wx < PW_B; wx = wx + 1)
				if (wr_b)
					extra_mem[xbase_b + wx] <= port_b_extra_in[wx];
		end
	end

	// port a output register
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			port_a_read_word_out <= {DW_A{`OUT_RESET}};
			port_a_extra_out     <= {PP_A{`OUT_RESET}};
		end
		else if (ce_in)
		begin
			if (act_a)
			begin
				if (preset_a)
				begin
					port_a_read_word_out <= PRESET_A;
					// an unused extra pin keeps reading zero
					for (ra = 0; ra < PW_A; ra = ra + 1)
						port_a_extra_out[ra] <= PRESET_X_A[ra];
				end
				else if (wr_a && MODE_A == `MODE_NEW)
				begin
					port_a_read_word_out <= port_a_write_word_in;
					for (ra = 0; ra < PW_A; ra = ra + 1)
						port_a_extra_out[ra] <= port_a_extra_in[ra];
				end
				else if (!(wr_a && MODE_A == `MODE_HOLD))
				begin
					// old-data mode and plain reads both see stored contents
					for (ra = 0; ra < DW_A; ra = ra + 1)
						port_a_read_word_out[ra] <= data_mem[base_a + ra];
					for (ra = 0; ra < PW_A; ra = ra + 1)
						port_a_extra_out[ra] <= extra_mem[xbase_a + ra];
				end
			end
		end
	end

	// port b output register, apart so each loop index has one driver
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			port_b_read_word_out <= {DW_B{`OUT_RESET}};
			port_b_extra_out     <= {PP_B{`OUT_RESET}};
		end
		else if (ce_in)
		begin
			if (act_b)
			begin
				if (preset_b)
				begin
					port_b_read_word_out <= PRESET_B;
					for (rb = 0; rb < PW_B; rb = rb + 1)
						port_b_extra_out[rb] <= PRESET_X_B[rb];
				end
				else if (wr_b && MODE_B == `MODE_NEW)
				begin
					port_b_read_word_out <= port_b_write_word_in;
					for (rb = 0; rb < PW_B; rb = rb + 1)
						port_b_extra_out[rb] <= port_b_extra_in[rb];
				end
				else if (!(wr_b && MODE_B == `MODE_HOLD))
				begin
					for (rb = 0; rb < DW_B; rb = rb + 1)
						port_b_read_word_out[rb] <= data_mem[base_b + rb];
					for (rb = 0; rb < PW_B; rb = rb + 1)
						port_b_extra_out[rb] <= extra_mem[xbase_b + rb];
				end
			end
		end
	end

endmodule

// [tb/port_fabric.sv]
// partner: fabric logic making one port clock pulse per request
// assumes requests at least three core cycles apart
`timescale 1ns/1ps
module port_fabric #(
	parameter [0:0] IDLE = 1'b0
) (
	input  wire core_clk_in,
	input  wire rst_in,
	input  wire go_in,
	output reg  clk_out
);
	// one cycle away from idle, then back, so the edge detector sees each pulse
	always @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
			clk_out <= IDLE;
		else
			clk_out <= go_in ^ IDLE;
endmodule

// [tb/ram_ports_props.sv]
// checker on port a of the dual-port memory
// assumes width 9 on port a, no inversion, preset word 5A
`timescale 1ns/1ps
module ram_ports_props (
	input wire       core_clk_in,
	input wire       rst_in,
	input wire       ce_in,
	input wire       port_a_clock_in,
	input wire       port_a_gate_in,
	input wire       port_a_write_strobe_in,
	input wire       port_a_sync_output_preset_in,
	input wire [7:0] port_a_write_word_in,
	input wire [0:0] port_a_extra_in,
	input wire [7:0] port_a_read_word_out,
	input wire [0:0] port_a_extra_out
);
	reg  k_q;
	wire e = ce_in && port_a_gate_in && port_a_clock_in && !k_q;
	wire w = e && port_a_write_strobe_in && !port_a_sync_output_preset_in;
	always @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
			k_q <= 1'b0;
		else if (ce_in)
			k_q <= port_a_clock_in;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	property p_wr; w |=> port_a_read_word_out == $past(port_a_write_word_in); endproperty
	a_wr: assert property (p_wr) else $error("write word lost");
	property p_wx; w |=> port_a_extra_out == $past(port_a_extra_in); endproperty
	a_wx: assert property (p_wx) else $error("extra bit lost");
	property p_pr; e && port_a_sync_output_preset_in |=> port_a_read_word_out == 8'h5A; endproperty
	a_pr: assert property (p_pr) else $error("preset not loaded");
	property p_px; e && port_a_sync_output_preset_in |=> port_a_extra_out == 1'h0; endproperty
	a_px: assert property (p_px) else $error("preset extra wrong");
	property p_gd; !port_a_gate_in |=> $stable(port_a_read_word_out); endproperty
	a_gd: assert property (p_gd) else $error("gated word moved");
	property p_gx; !port_a_gate_in |=> $stable(port_a_extra_out); endproperty
	a_gx: assert property (p_gx) else $error("gated extra moved");
	property p_lo; !port_a_clock_in |=> $stable(port_a_read_word_out); endproperty
	a_lo: assert property (p_lo) else $error("moved without edge");
	property p_hi; port_a_clock_in && k_q |=> $stable(port_a_read_word_out); endproperty
	a_hi: assert property (p_hi) else $error("moved on held clock");
	c_wr: cover property (w);
	c_pr: cover property (e && port_a_sync_output_preset_in);
	c_gd: cover property (!port_a_gate_in && port_a_clock_in);
endmodule
bind dual_port_block_ram_ports ram_ports_props chk_i (.*);

// [tb/testbench.sv]
// bench: port a 9 wide, port b 36 wide in old-data mode with all controls inverted
// assumes shared/ on the include path
`timescale 1ns/1ps
`include "bram_consts.vh"
module testbench;
	reg clk = 0, rst = 1, ca = 0, cb = 0, ga = 0, gb = 1, wa = 0, wb = 1, pa = 0, pb = 1, ce = 1;
	reg [10:0] la = 0;
	reg [8:0]  lb = 0;
	reg [8:0]  da = 0;
	reg [35:0] db = 0;
	wire ka, kb;
	wire [7:0] qa;
	wire [0:0] ya;
	wire [31:0] qb;
	wire [3:0] yb;
	integer failures = 0, n_tests = 0, cyc = 0, i;
	port_fabric port_fabric_i (.core_clk_in(clk), .rst_in(rst), .go_in(ca), .clk_out(ka));
	// inverted port clock idles high, so its active edge is the fall
	port_fabric #(.IDLE(1'b1))
	port_fabric_b_i (.core_clk_in(clk), .rst_in(rst), .go_in(cb), .clk_out(kb));
	dual_port_block_ram_ports #(.WIDTH_B(36), .MODE_B(`MODE_OLD), .PRESET_A(8'h5A),
		.INV_B(4'hF), .PRESET_B(32'h13572468))
	dual_port_block_ram_ports_i (.core_clk_in(clk), .rst_in(rst), .ce_in(ce),
		.port_a_clock_in(ka), .port_a_gate_in(ga), .port_a_write_strobe_in(wa),
		.port_a_sync_output_preset_in(pa), .port_a_location_in(la),
		.port_a_write_word_in(da[7:0]), .port_a_extra_in(da[8]),
		.port_a_read_word_out(qa), .port_a_extra_out(ya), .port_b_clock_in(kb),
		.port_b_gate_in(gb), .port_b_write_strobe_in(wb), .port_b_sync_output_preset_in(pb),
		.port_b_location_in(lb), .port_b_write_word_in(db[31:0]), .port_b_extra_in(db[35:32]),
		.port_b_read_word_out(qb), .port_b_extra_out(yb));
	initial
		forever #5 clk = ~clk;
	task close_out;
	begin
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	task chk(input [35:0] g, input [35:0] x);
	begin
		n_tests = n_tests + 1;
		if (g !== x)
		begin
			failures = failures + 1;
			$display("[FAIL] %0t got %h want %h", $time, g, x);
		end
	end
	endtask
	// gates drop only after the edge that the design samples, then the partner settles
	task pulse;
	begin
		@(posedge clk);
		ca <= 0;
		cb <= 0;
		@(posedge clk);
		ga <= 0;
		gb <= 1;
		repeat (2) @(posedge clk);
	end
	endtask
	task op_a(input [10:0] l, input [8:0] d, input g, input w, input p);
	begin
		{la, da, ga, wa, pa, ca} <= {l, d, g, w, p, 1'b1};
		pulse;
	end
	endtask
	// port b gate, strobe and preset pins are low-active
	task op_b(input [8:0] l, input [35:0] d, input g, input w, input p);
	begin
		{lb, db, gb, wb, pb, cb} <= {l, d, ~g, ~w, ~p, 1'b1};
		pulse;
	end
	endtask
	task t_pair;
	begin
		op_b(9'h001, 36'h944332211, 1, 1, 0);
		// one wide word reads back as four narrow words, low address low byte
		for (i = 0; i < 4; i = i + 1)
		begin
			op_a(11'h004 + i, 0, 1, 0, 0);
			chk({ya, qa}, {db[32 + i], db[8 * i +: 8]});
		end
		op_b(9'h001, 36'h588776655, 1, 1, 0);
		chk({yb, qb}, 36'h944332211);
		$display("t_pair done");
	end
	endtask
	task t_gate;
	begin
		op_a(11'h004, 9'h1FF, 0, 1, 0);
		op_a(11'h004, 0, 1, 0, 0);
		chk({ya, qa}, 9'h155);
		op_a(11'h005, 9'h0A5, 1, 1, 0);
		chk({ya, qa}, 9'h0A5);
		op_b(9'h001, 36'hFFFFFFFFF, 0, 1, 0);
		chk({yb, qb}, 36'h944332211);
		op_b(9'h001, 0, 1, 0, 0);
		chk({yb, qb}, 36'h58877A555);
		$display("t_gate done");
	end
	endtask
	// a low clock enable must freeze the port edge, the store and the output
	task t_freeze;
	begin
		ce <= 0;
		op_a(11'h004, 9'h1FF, 1, 1, 0);
		chk({ya, qa}, 9'h0A5);
		ce <= 1;
		op_a(11'h004, 0, 1, 0, 0);
		chk({ya, qa}, 9'h155);
		$display("t_freeze done");
	end
	endtask
	task t_preset;
	begin
		op_a(11'h006, 9'h1C3, 1, 1, 1);
		chk({ya, qa}, 9'h05A);
		op_a(11'h006, 0, 1, 0, 0);
		chk({ya, qa}, 9'h1C3);
		op_b(9'h002, 0, 1, 0, 1);
		chk({yb, qb}, 36'h013572468);
		$display("t_preset done");
	end
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 500)
		begin
			failures = failures + 1;
			close_out;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_pair;
		t_gate;
		t_freeze;
		t_preset;
		close_out;
	end
endmodule
